// ==== rtl/vdr_regs.vh ====
`ifndef VDR_REGS_VH
`define VDR_REGS_VH

// Packet and register file geometry
`define VDR_FP_W        256
`define VDR_IW          32
`define VDR_SLOTS       8
`define VDR_UNITS       8
`define VDR_NREG        32
`define VDR_RW          32
`define VDR_AW          5

// Common instruction fields
`define VDR_CHAIN_BIT   0
`define VDR_UNIT_LSB    1
`define VDR_CREG_LSB    29
`define VDR_DST_LSB     24
`define VDR_SRC1_LSB    19
`define VDR_SRC2_LSB    14
`define VDR_XP_BIT      13

// Addressing unit fields
`define VDR_CIRC_BIT    4
`define VDR_LONG_BIT    5
`define VDR_SIZE_LSB    6
`define VDR_STORE_BIT   8
`define VDR_OFF_LSB     9
`define VDR_BASE_LSB    19
`define VDR_DXP_BIT     14
`define VDR_LONG_BASE   5'h0e

// Unit slot within a side
`define VDR_LOGIC_UNIT  2'h0
`define VDR_SHIFT_UNIT  2'h1
`define VDR_MULT_UNIT   2'h2
`define VDR_ADDR_UNIT   2'h3

// Access sizes
`define VDR_SZ_BYTE     2'h0
`define VDR_SZ_HALF     2'h1
`define VDR_SZ_WORD     2'h2
`define VDR_SZ_DWORD    2'h3

// Reset values and defaults
`define VDR_CREG_NONE   3'h0
`define VDR_PTR_RST     4'h0
`define VDR_CIRC_BITS   8

`endif

// ==== rtl/vdr_regfile.v ====
`timescale 1ns/1ns
`include "vdr_regs.vh"

module vdr_regfile #(
  parameter NREG = `VDR_NREG,
  parameter W    = `VDR_RW,
  parameter AW   = `VDR_AW,
  parameter NWP  = 8
) (
  // Clock and reset
  input  wire                core_clk,
  input  wire                rst,
  // Write ports, later ports win
  input  wire [NWP-1:0]      wr_en,
  input  wire [NWP*AW-1:0]   wr_addr,
  input  wire [NWP*W-1:0]    wr_data,
  // Every word at once, and which words were written at the last edge
  output wire [NREG*W-1:0]   rd_all,
  output wire [NREG-1:0]     wr_mask
);

  genvar g;
  generate
    for (g = 0; g < NREG; g = g + 1) begin : gw
      localparam [AW-1:0] IDX = g;
      reg [W-1:0] word_r;
      reg [W-1:0] word_nxt;
      reg         hit;
      reg         written_r;
      integer     p;

      always @* begin
        hit = 1'b0;
        word_nxt = word_r;
        for (p = 0; p < NWP; p = p + 1) begin
          if (wr_en[p] && (wr_addr[p*AW +: AW] == IDX)) begin
            hit = 1'b1;
            word_nxt = wr_data[p*W +: W];
          end
        end
      end

      always @(posedge core_clk) begin
        if (rst) begin
          word_r    <= {W{1'b0}};
          written_r <= 1'b0;
        end else begin
          word_r    <= word_nxt;
          written_r <= hit;
        end
      end

      assign rd_all[g*W +: W] = word_r;
      assign wr_mask[g]       = written_r;
    end
  endgenerate

endmodule

// ==== rtl/vdr_dispatch.v ====
// Contract
// - Instructions arrive as whole 256-bit fetch packets.
// - Up to eight 32-bit instructions issue per clock, one per unit.
// - A per-instruction chaining bit decides packet membership versus next clock.
// - Chaining bit is the instruction LSB; 1 links, 0 ends the packet.
// - Execute packets vary in length; one fetch packet may hold several.
// - One execute packet per clock; refetch only when packet drained; may span.
// - Two sides, four units each, each with 32 registers of 32 bits.
// - Files hold packed 8/16-bit, 32/40-bit and 64-bit values in pairs.
// - Same-side units read any own register within one clock.
// - Each side has a cross path to every register of the other file.
// - Cross reads are pipelined so several units share one register.
// - One stall clock when a cross read hits a register written last clock.
// - Compute works on registers; only addressing units touch memory.
// - Addressing unit may use one side's address with the other side's data.
// - Loads and stores move 8, 16, 32 or 64 bits in one instruction.
// - Word and doubleword accesses may start at any byte address.
// - Linear and circular addressing with 5-bit or 15-bit offsets.
// - All instructions conditional; dedicated registers hold conditions and bases.
// - Packed four 8-bit or two 16-bit lanes reach the units intact.
`timescale 1ns/1ns
`include "vdr_regs.vh"

module vdr_dispatch #(
  parameter CIRC_BITS = `VDR_CIRC_BITS
) (
  // Clock and reset
  input  wire                         core_clk,
  input  wire                         rst,
  // Fetch
  output wire                         fetch_req,
  input  wire                         fetch_valid,
  input  wire [`VDR_FP_W-1:0]         fetch_packet,
  // Issue to the eight units
  output wire [`VDR_UNITS-1:0]        unit_valid,
  output wire [`VDR_UNITS-1:0]        unit_exec,
  output wire [`VDR_UNITS*32-1:0]     unit_instr,
  output wire [`VDR_UNITS*32-1:0]     unit_op1,
  output wire [`VDR_UNITS*32-1:0]     unit_op2,
  output reg                          xp_stall_r,
  // Unit results
  input  wire [`VDR_UNITS-1:0]        wb_en,
  input  wire [`VDR_UNITS*5-1:0]      wb_dst,
  input  wire [`VDR_UNITS*32-1:0]     wb_data,
  // Data memory, one channel per addressing unit
  output wire [1:0]                   mem_req,
  output wire [1:0]                   mem_we,
  output wire [3:0]                   mem_size,
  output wire [63:0]                  mem_addr,
  output wire [127:0]                 mem_wdata,
  input  wire [1:0]                   mem_rvalid,
  input  wire [127:0]                 mem_rdata
);

  // Bits in one whole register file
  localparam NRW = `VDR_NREG * `VDR_RW;

  // Current fetch packet and the partial execute packet carried over a boundary
  reg  [`VDR_FP_W-1:0]     fp_r;
  reg                      fp_valid_r;
  reg  [3:0]               ptr_r;
  reg  [`VDR_UNITS-1:0]    pend_v_r;
  reg  [`VDR_UNITS*32-1:0] pend_i_r;
  reg                      stall_done_r;

  reg  [`VDR_SLOTS-1:0]    take;
  reg                      ended;
  reg  [3:0]               np;
  reg  [`VDR_UNITS-1:0]    iv;
  reg  [`VDR_UNITS*32-1:0] ii;
  reg  [2:0]               uidx;
  integer                  s;

  wire [2*NRW-1:0]         rf_flat;
  wire [2*`VDR_NREG-1:0]   wm_flat;
  wire [NRW-1:0]           rf_a;
  wire [`VDR_UNITS-1:0]    xhit;
  wire [`VDR_UNITS-1:0]    pass;
  wire                     go;
  wire                     need_stall;
  wire                     issue;

  // Load return path, one entry per addressing unit
  wire [1:0]               ld_lo_en;
  wire [1:0]               ld_hi_en;
  wire [1:0]               ld_side;
  wire [9:0]               ld_dst;
  wire [9:0]               ld_dst_hi;
  wire [63:0]              ld_lo;
  wire [63:0]              ld_hi;

  // One register out of a flattened file
  function [31:0] rd_word;
    input [NRW-1:0] all;
    input [4:0]     a;
    begin
      rd_word = all[a*32 +: 32];
    end
  endfunction

  // Side A file also holds the condition registers
  assign rf_a = rf_flat[NRW-1:0];
  // Ask for a packet whenever none is held
  assign fetch_req = ~fp_valid_r;

  // Walk the fetch packet from the pointer up to the first unchained slot
  always @* begin
    take  = {`VDR_SLOTS{1'b0}};
    ended = 1'b0;
    np    = ptr_r;
    iv    = pend_v_r;
    ii    = pend_i_r;
    uidx  = 3'h0;
    for (s = 0; s < `VDR_SLOTS; s = s + 1) begin
      if (fp_valid_r && (s >= ptr_r) && !ended) begin
        take[s] = 1'b1;
        // A later slot naming the same unit wins
        uidx = fp_r[s*32 + `VDR_UNIT_LSB +: 3];
        iv[uidx] = 1'b1;
        ii[uidx*32 +: 32] = fp_r[s*32 +: 32];
        np = s[3:0] + 4'h1;
        if (!fp_r[s*32 + `VDR_CHAIN_BIT]) begin
          ended = 1'b1;
        end
      end
    end
  end

  // Hold a packet one clock when a cross read meets a fresh write
  assign go         = fp_valid_r & ended;
  assign need_stall = go & (|xhit) & ~stall_done_r;
  assign issue      = go & ~need_stall;

  // Fetch holder, carry-over packet and slot pointer
  always @(posedge core_clk) begin
    if (rst) begin
      fp_r         <= {`VDR_FP_W{1'b0}};
      fp_valid_r   <= 1'b0;
      ptr_r        <= `VDR_PTR_RST;
      pend_v_r     <= {`VDR_UNITS{1'b0}};
      pend_i_r     <= {(`VDR_UNITS*32){1'b0}};
      stall_done_r <= 1'b0;
      xp_stall_r   <= 1'b0;
    end else begin
      // A stalled packet goes through on the next try
      stall_done_r <= need_stall;
      xp_stall_r   <= need_stall;
      if (fetch_req && fetch_valid) begin
        fp_r       <= fetch_packet;
        fp_valid_r <= 1'b1;
        ptr_r      <= `VDR_PTR_RST;
      end else if (fp_valid_r && !ended) begin
        // Chain runs off the end: hold the partial packet, fetch the next one
        pend_v_r   <= iv;
        pend_i_r   <= ii;
        fp_valid_r <= 1'b0;
      end else if (issue) begin
        pend_v_r <= {`VDR_UNITS{1'b0}};
        ptr_r    <= np;
        // Last execute packet of the fetch packet frees the holder
        if (np == 4'h8) begin
          fp_valid_r <= 1'b0;
        end
      end
    end
  end

  // Two register files, each written by its own units and by returning loads
  genvar gs;
  generate
    for (gs = 0; gs < 2; gs = gs + 1) begin : gside
      localparam SIDE_BIT = gs;
      wire [1:0] sel;
      assign sel[0] = (ld_side[0] == SIDE_BIT[0]);
      assign sel[1] = (ld_side[1] == SIDE_BIT[0]);

      // Unit results take the low ports and loads the high ones, so loads win
      vdr_regfile #(
        .NREG (`VDR_NREG),
        .W    (`VDR_RW),
        .AW   (`VDR_AW),
        .NWP  (8)
      ) u_rf (
        .core_clk (core_clk),
        .rst      (rst),
        .wr_en    ({ld_hi_en & sel, ld_lo_en & sel, wb_en[gs*4 +: 4]}),
        .wr_addr  ({ld_dst_hi, ld_dst, wb_dst[gs*20 +: 20]}),
        .wr_data  ({ld_hi, ld_lo, wb_data[gs*128 +: 128]}),
        .rd_all   (rf_flat[gs*NRW +: NRW]),
        .wr_mask  (wm_flat[gs*`VDR_NREG +: `VDR_NREG])
      );
    end
  endgenerate

  // Per-unit operand fetch, condition check and issue registers
  genvar gu;
  generate
    for (gu = 0; gu < `VDR_UNITS; gu = gu + 1) begin : gunit
      // Units 0-3 sit on side A, 4-7 on side B
      localparam SIDE = gu / 4;
      localparam IS_ADDR = ((gu % 4) == 3);
      wire [31:0]          ins = ii[gu*32 +: 32];
      wire [NRW-1:0]       own = rf_flat[SIDE*NRW +: NRW];
      wire [NRW-1:0]       oth = rf_flat[(1-SIDE)*NRW +: NRW];
      wire [`VDR_NREG-1:0] oth_wm = wm_flat[(1-SIDE)*`VDR_NREG +: `VDR_NREG];
      wire [2:0]           creg = ins[`VDR_CREG_LSB +: 3];
      wire                 xp;
      wire [4:0]           xreg;
      wire [31:0]          op1_nxt;
      wire [31:0]          op2_nxt;
      wire                 xrd;

      reg                  valid_r;
      reg                  exec_r;
      reg  [31:0]          instr_r;
      reg  [31:0]          op1_r;
      reg  [31:0]          op2_r;

      // Condition registers are the low words of side A
      assign pass[gu] = (creg == `VDR_CREG_NONE) ||
                        (rd_word(rf_a, {2'h0, creg}) != 32'h0);
      // Addressing units go across only in short mode, and read there only for stores
      assign xp   = IS_ADDR ? (ins[`VDR_DXP_BIT] & ~ins[`VDR_LONG_BIT]) : ins[`VDR_XP_BIT];
      assign xreg = IS_ADDR ? ins[`VDR_DST_LSB +: 5] : ins[`VDR_SRC2_LSB +: 5];
      assign xrd  = IS_ADDR ? ins[`VDR_STORE_BIT] : 1'b1;
      assign xhit[gu] = iv[gu] & xp & xrd & oth_wm[xreg];

      if (IS_ADDR) begin : gaddr
        wire        long_off = ins[`VDR_LONG_BIT];
        wire [4:0]  base_reg = long_off ? `VDR_LONG_BASE : ins[`VDR_BASE_LSB +: 5];
        wire [31:0] base = rd_word(own, base_reg);
        wire [1:0]  size = ins[`VDR_SIZE_LSB +: 2];
        wire [14:0] off  = long_off ? ins[`VDR_OFF_LSB +: 15]
                                    : {10'h000, ins[`VDR_OFF_LSB +: 5]};
        // Offsets count in units of the access size
        wire [31:0] scaled = {17'h00000, off} << size;
        wire [31:0] lin = base + scaled;
        wire [31:0] addr_nxt;
        wire [4:0]  dreg = ins[`VDR_DST_LSB +: 5];
        wire [4:0]  dreg_hi = dreg + 5'h01;
        // Short mode may take the data register from the other file
        wire [NRW-1:0] dfile = xp ? oth : own;
        wire        dside = xp ? (SIDE == 0) : (SIDE == 1);
        reg         req_r;
        reg         we_r;
        reg  [1:0]  size_r;
        reg  [31:0] addr_r;
        reg  [63:0] wdata_r;
        reg         ld_side_r;
        reg  [4:0]  ld_dst_r;
        reg  [1:0]  ld_size_r;
        reg  [31:0] ld_word;

        // Circular mode wraps inside a block of 2**CIRC_BITS bytes
        assign addr_nxt = ins[`VDR_CIRC_BIT] ? {base[31:CIRC_BITS], lin[CIRC_BITS-1:0]}
                                             : lin;
        // Addressing units pass the base and the data register on
        assign op1_nxt = base;
        assign op2_nxt = rd_word(dfile, dreg);

        always @(posedge core_clk) begin
          if (rst) begin
            req_r     <= 1'b0;
            we_r      <= 1'b0;
            size_r    <= `VDR_SZ_BYTE;
            addr_r    <= 32'h0;
            wdata_r   <= 64'h0;
            ld_side_r <= 1'b0;
            ld_dst_r  <= 5'h00;
            ld_size_r <= `VDR_SZ_BYTE;
          end else begin
            req_r <= issue & iv[gu] & pass[gu];
            if (issue && iv[gu]) begin
              we_r    <= ins[`VDR_STORE_BIT];
              size_r  <= size;
              addr_r  <= addr_nxt;
              // Store data is a register pair; narrow stores use the low bits
              wdata_r <= {rd_word(dfile, dreg_hi), op2_nxt};
              if (!ins[`VDR_STORE_BIT] && pass[gu]) begin
                ld_side_r <= dside;
                ld_dst_r  <= dreg;
                ld_size_r <= size;
              end
            end
          end
        end

        // Narrow loads are zero extended into the low bits of the target
        always @* begin
          case (ld_size_r)
            `VDR_SZ_BYTE: ld_word = {24'h000000, mem_rdata[SIDE*64 +: 8]};
            `VDR_SZ_HALF: ld_word = {16'h0000, mem_rdata[SIDE*64 +: 16]};
            default:      ld_word = mem_rdata[SIDE*64 +: 32];
          endcase
        end

        // Channel outputs and load return for this side
        assign mem_req[SIDE]            = req_r;
        assign mem_we[SIDE]             = we_r;
        assign mem_size[SIDE*2 +: 2]    = size_r;
        assign mem_addr[SIDE*32 +: 32]  = addr_r;
        assign mem_wdata[SIDE*64 +: 64] = wdata_r;
        assign ld_lo_en[SIDE]           = mem_rvalid[SIDE];
        assign ld_hi_en[SIDE]           = mem_rvalid[SIDE] && (ld_size_r == `VDR_SZ_DWORD);
        assign ld_side[SIDE]            = ld_side_r;
        assign ld_dst[SIDE*5 +: 5]      = ld_dst_r;
        assign ld_dst_hi[SIDE*5 +: 5]   = ld_dst_r + 5'h01;
        assign ld_lo[SIDE*32 +: 32]     = ld_word;
        assign ld_hi[SIDE*32 +: 32]     = mem_rdata[SIDE*64 + 32 +: 32];
      end else begin : gcomp
        // Compute units: src1 from the own file, src2 own or across
        assign op1_nxt = rd_word(own, ins[`VDR_SRC1_LSB +: 5]);
        assign op2_nxt = xp ? rd_word(oth, xreg)
                            : rd_word(own, xreg);
      end

      // Operands are registered, so a cross read never limits same-packet sharing
      always @(posedge core_clk) begin
        if (rst) begin
          valid_r <= 1'b0;
          exec_r  <= 1'b0;
          instr_r <= 32'h0;
          op1_r   <= 32'h0;
          op2_r   <= 32'h0;
        end else begin
          valid_r <= issue & iv[gu];
          exec_r  <= issue & iv[gu] & pass[gu];
          if (issue && iv[gu]) begin
            instr_r <= ins;
            op1_r   <= op1_nxt;
            op2_r   <= op2_nxt;
          end
        end
      end

      assign unit_valid[gu]          = valid_r;
      assign unit_exec[gu]           = exec_r;
      assign unit_instr[gu*32 +: 32] = instr_r;
      assign unit_op1[gu*32 +: 32]   = op1_r;
      assign unit_op2[gu*32 +: 32]   = op2_r;
    end
  endgenerate

endmodule

// ==== testbench/vdr_dispatch_checker.sv ====
`timescale 1ns/1ns
module vdr_dispatch_checker (
  // Clock and reset
  input wire         core_clk,
  input wire         rst,
  // Fetch and issue
  input wire         fetch_req,
  input wire         fetch_valid,
  input wire [7:0]   unit_valid,
  input wire [7:0]   unit_exec,
  input wire [255:0] unit_instr,
  input wire [255:0] unit_op1,
  input wire         xp_stall_r,
  // Data memory
  input wire [1:0]   mem_req,
  input wire [1:0]   mem_we,
  input wire [3:0]   mem_size
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_gap;
    xp_stall_r && unit_valid == 8'h00;
  endsequence
  sequence s_resume;
    unit_valid != 8'h00 && !xp_stall_r;
  endsequence

  property p_rst_out;
    $fell(rst) |-> fetch_req && unit_valid == 8'h00 && mem_req == 2'h0 && !xp_stall_r;
  endproperty
  property p_take;
    fetch_req && fetch_valid |=> !fetch_req;
  endproperty
  property p_wait;
    fetch_req && !fetch_valid |=> fetch_req;
  endproperty
  property p_exec;
    (unit_exec & ~unit_valid) == 8'h00;
  endproperty
  property p_mem_a;
    mem_req[0] |-> unit_exec[3] && mem_size[1:0] == unit_instr[103:102]
      && mem_we[0] == unit_instr[104];
  endproperty
  property p_mem_b;
    mem_req[1] |-> unit_exec[7] && mem_size[3:2] == unit_instr[231:230]
      && mem_we[1] == unit_instr[232];
  endproperty
  property p_hold;
    !unit_valid[0] |-> $stable(unit_instr[31:0]) && $stable(unit_op1[31:0]);
  endproperty
  // A stall leaves one empty issue slot, then the packet goes out
  property p_stall;
    xp_stall_r |-> s_gap ##1 s_resume;
  endproperty

  a_rst_out: assert property (p_rst_out) else $error("outputs wrong after reset");
  a_take:    assert property (p_take) else $error("fetch request kept after take");
  a_wait:    assert property (p_wait) else $error("fetch request dropped untaken");
  a_exec:    assert property (p_exec) else $error("exec without issue");
  a_mem_a:   assert property (p_mem_a) else $error("channel 0 request mismatch");
  a_mem_b:   assert property (p_mem_b) else $error("channel 1 request mismatch");
  a_hold:    assert property (p_hold) else $error("unit 0 outputs moved idle");
  a_stall:   assert property (p_stall) else $error("stall slot wrong");
endmodule

bind vdr_dispatch vdr_dispatch_checker chk (
  .core_clk(core_clk), .rst(rst), .fetch_req(fetch_req), .fetch_valid(fetch_valid),
  .unit_valid(unit_valid), .unit_exec(unit_exec), .unit_instr(unit_instr),
  .unit_op1(unit_op1), .xp_stall_r(xp_stall_r), .mem_req(mem_req), .mem_we(mem_we),
  .mem_size(mem_size)
);

// ==== testbench/vdr_mem_model.sv ====
`timescale 1ns/1ns
module vdr_mem_model #(
  parameter LAT = 3
) (
  // Clock and reset
  input  wire         core_clk,
  input  wire         rst,
  // Program side
  input  wire         fetch_req,
  output reg          fetch_valid,
  output reg  [255:0] fetch_packet,
  // Data side
  input  wire [1:0]   mem_req,
  input  wire [1:0]   mem_we,
  input  wire [63:0]  mem_addr,
  output reg  [1:0]   mem_rvalid,
  output reg  [127:0] mem_rdata
);
  logic [255:0] prog[$];
  logic [255:0] last;
  int           cnt[2];
  logic [31:0]  la[2];
  initial begin
    fetch_valid = 1'b0;
    fetch_packet = 256'h0;
    mem_rvalid = 2'h0;
    mem_rdata = 128'h0;
    last = 256'h0;
    cnt = '{0, 0};
  end
  always @(posedge core_clk) begin : step
    logic        tk;
    logic [1:0]  ld;
    logic [63:0] a;
    tk = fetch_req && fetch_valid && !rst;
    ld = mem_req & ~mem_we;
    a = mem_addr;
    #2;
    if (tk)
      last = prog.pop_front();
    // Lines not offered show the inverse of the last packet
    fetch_valid = prog.size() != 0;
    fetch_packet = fetch_valid ? prog[0] : ~last;
    for (int c = 0; c < 2; c++) begin
      mem_rvalid[c] = 1'b0;
      mem_rdata[c*64+:64] = ~mem_rdata[c*64+:64];
      if (cnt[c] == 1) begin
        mem_rvalid[c] = 1'b1;
        mem_rdata[c*64+:64] = {32'hbeef0000 ^ la[c], 32'hc0de0000 ^ la[c]};
      end
      if (cnt[c] > 0)
        cnt[c]--;
      if (ld[c]) begin
        cnt[c] = LAT;
        la[c] = a[c*32+:32];
      end
    end
  end
endmodule

// ==== testbench/wide_instruction_word_dispatch_regfile_crosspath_bench.sv ====
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module wide_instruction_word_dispatch_regfile_crosspath_bench;
  reg          core_clk;
  reg          rst;
  reg  [7:0]   wb_en;
  reg  [39:0]  wb_dst;
  reg  [255:0] wb_data;
  wire         fetch_req;
  wire         fetch_valid;
  wire         xp_stall_r;
  wire [255:0] fetch_packet;
  wire [255:0] unit_instr;
  wire [255:0] unit_op1;
  wire [255:0] unit_op2;
  wire [7:0]   unit_valid;
  wire [7:0]   unit_exec;
  wire [1:0]   mem_req;
  wire [1:0]   mem_we;
  wire [1:0]   mem_rvalid;
  wire [3:0]   mem_size;
  wire [63:0]  mem_addr;
  wire [127:0] mem_wdata;
  wire [127:0] mem_rdata;
  int          errors;
  int          num_checks;
  int          nx;
  logic [7:0]  vq[$];
  logic [7:0]  eq[$];
  logic [34:0] mq[$];
  logic [31:0] op1;
  logic [31:0] op2;
  logic [63:0] wd;
  localparam [31:0] FL = 32'h00000002;

  vdr_dispatch dut (
    .core_clk(core_clk), .rst(rst), .fetch_req(fetch_req), .fetch_valid(fetch_valid),
    .fetch_packet(fetch_packet), .unit_valid(unit_valid), .unit_exec(unit_exec),
    .unit_instr(unit_instr), .unit_op1(unit_op1), .unit_op2(unit_op2),
    .xp_stall_r(xp_stall_r), .wb_en(wb_en), .wb_dst(wb_dst), .wb_data(wb_data),
    .mem_req(mem_req), .mem_we(mem_we), .mem_size(mem_size), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata)
  );
  vdr_mem_model pm (
    .core_clk(core_clk), .rst(rst), .fetch_req(fetch_req), .fetch_valid(fetch_valid),
    .fetch_packet(fetch_packet), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata)
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(negedge core_clk) begin
    if (!rst && unit_valid != 8'h00) begin
      vq.push_back(unit_valid);
      eq.push_back(unit_exec);
    end
    if (unit_valid[0]) begin
      op1 = unit_op1[31:0];
      op2 = unit_op2[31:0];
    end
    if (mem_req[0])
      mq.push_back({mem_we[0], mem_size[1:0], mem_addr[31:0]});
    if (mem_req[1])
      mq.push_back({mem_we[1], mem_size[3:2], mem_addr[63:32]});
    if (mem_req[0] && mem_we[0])
      wd = mem_wdata[63:0];
    if (mem_req[1] && mem_we[1])
      wd = mem_wdata[127:64];
    if (xp_stall_r)
      nx++;
  end

  function [31:0] ins(input [2:0] c, input [4:0] d, s1, s2, input x, input [2:0] u, input ch);
    ins = {c, d, s1, s2, x, 9'h000, u, ch};
  endfunction
  function [31:0] ld(input [4:0] d, b, off, input [1:0] sz, input st);
    ld = {3'h0, d, b, 4'h0, 1'b0, off, st, sz, 2'h0, 3'h3, 1'b0};
  endfunction
  task clr;
    vq.delete();
    eq.delete();
    mq.delete();
    nx = 0;
  endtask
  task wt(input int n);
    for (int i = 0; i < 80 && vq.size() < n; i++)
      @(posedge core_clk);
    repeat (6) @(posedge core_clk);
    #1;
  endtask

  task t_reset;
    `CHK(fetch_req, 1'b1)
    `CHK(unit_valid, 8'h00)
    $display("reset test done");
  endtask
  task t_split;
    logic [255:0] p;
    logic [7:0]   ex[12];
    ex = '{8'h03, 8'h04, 8'h70, 8'h01, 8'h06, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02};
    for (int s = 0; s < 8; s++)
      p[s*32+:32] = ins(0, 0, 0, 0, 0, 24'o10654210 >> (s * 3), 8'b10011001 >> s);
    clr;
    pm.prog.push_back(p);
    pm.prog.push_back({{7{FL}}, ins(0, 0, 0, 0, 0, 2, 0)});
    wt(12);
    `CHK(vq.size(), 12)
    for (int i = 0; i < 12; i++) begin
      `CHK(vq[i], ex[i])
      `CHK(eq[i], ex[i])
    end
    $display("split test done");
  endtask
  task t_cross;
    clr;
    wb_en = 8'h10;
    wb_dst[24:20] = 5'h05;
    wb_data[159:128] = 32'h5a5a0001;
    pm.prog.push_back({{7{FL}}, ins(0, 0, 0, 5, 1, 0, 0)});
    wt(8);
    `CHK(nx, 1)
    `CHK(op2, 32'h5a5a0001)
    wb_en = 8'h00;
    $display("cross test done");
  endtask
  task t_mem;
    logic [255:0] p;
    wb_en = 8'h01;
    wb_dst[4:0] = 5'h01;
    wb_data[31:0] = 32'h00000003;
    @(posedge core_clk);
    #1;
    wb_en = 8'h00;
    clr;
    p = {FL, FL, 192'h0};
    p[31:0] = ld(0, 1, 2, 2, 1);
    p[63:32] = ins(2, 0, 0, 0, 0, 1, 0);
    for (int k = 0; k < 4; k++)
      p[(k+2)*32+:32] = ld(6, 0, 3, k, 0);
    pm.prog.push_back(p);
    // No load-use interlock: the read waits behind seven filler packets
    pm.prog.push_back({ins(0, 0, 6, 7, 0, 0, 0), {7{FL}}});
    wt(16);
    `CHK(mq.size(), 5)
    `CHK(mq[0], {1'b1, 2'h2, 32'h0000000b})
    `CHK(wd, 64'h0000000300000000)
    for (int k = 0; k < 4; k++)
      `CHK(mq[k+1], {1'b0, k[1:0], 32'h3 << k})
    `CHK(vq[1], 8'h02)
    `CHK(eq[1], 8'h00)
    `CHK(op1, 32'hc0de0018)
    `CHK(op2, 32'hbeef0018)
    $display("memory test done");
  endtask

  task t_side;
    wb_en = 8'h10;
    wb_dst[24:20] = 5'h01;
    wb_data[159:128] = 32'h000001f0;
    @(posedge core_clk);
    #1;
    wb_en = 8'h00;
    clr;
    // Channel 1: circular store of side A data, then a long-offset half load
    pm.prog.push_back({{6{FL}}, ld(2, 1, 4, 1, 0) | 32'h00000028,
                       ld(1, 1, 5, 2, 1) | 32'h00004018});
    pm.prog.push_back({ins(0, 0, 0, 2, 1, 0, 0), {7{FL}}});
    wt(16);
    `CHK(mq.size(), 2)
    `CHK(mq[0], {1'b1, 2'h2, 32'h00000104})
    `CHK(wd, 64'h0000000000000003)
    `CHK(mq[1], {1'b0, 2'h1, 32'h00000808})
    `CHK(op2, 32'h00000808)
    `CHK(nx, 0)
    $display("side B test done");
  endtask

  task results;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    #400000;
    errors++;
    results;
  end
  initial begin
    rst = 1'b1;
    wb_en = 8'h00;
    wb_dst = 40'h0;
    wb_data = 256'h0;
    errors = 0;
    num_checks = 0;
    repeat (8) @(posedge core_clk);
    #1;
    rst = 1'b0;
    @(posedge core_clk);
    #1;
    t_reset;
    t_split;
    t_cross;
    t_mem;
    t_side;
    results;
  end
endmodule
